/* File: pss_pkg.sv */
// Purpose: shared constants and types for the power supervisor sequencer
// Assumes: one 100 MHz clock, comparator levels arrive asynchronously
// Notes:   timing counts derive from times given in microseconds
package pss_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ            = 100;
    localparam int REG_SETTLE_US      = 20;
    localparam int CP_SETTLE_US       = 20;
    localparam int CLK_SETTLE_US      = 2;
    localparam int REG_SETTLE_CYC     = REG_SETTLE_US * CLK_MHZ;
    localparam int CP_SETTLE_CYC      = CP_SETTLE_US * CLK_MHZ;
    localparam int CLK_SETTLE_CYC     = CLK_SETTLE_US * CLK_MHZ;
    localparam int QUAL_TIME_US       = 1000;
    localparam int QUAL_CYC_DEF       = QUAL_TIME_US * CLK_MHZ;
    localparam int CP_REFRESH_DIV     = 3200;
    localparam int CNT_W              = 24;
    localparam int SETTLE_W           = 12;
    localparam int MON_W              = 16;
    localparam int VSET_W             = 4;
    localparam logic [VSET_W-1:0] VSET_MAX     = 4'hf;
    localparam logic [VSET_W-1:0] VSET_RST     = 4'h0;
    localparam logic [MON_W-1:0]  MON_CNT_RST  = 16'h0000;
    localparam logic [MON_W-1:0]  MON_CNT_MAX  = 16'hffff;

    typedef enum logic [3:0] {
        ST_OFF, ST_QUAL, ST_REG_ON, ST_CP_ON, ST_CLK_ON, ST_EXT_CLK, ST_BOOT, ST_RUN
    } pss_state_e;
endpackage : pss_pkg

/* File: pss_sequencer.sv */
// Purpose: power supervisor and power-on-reset boot sequencer
// Assumes: analog comparators decide the voltage thresholds, this logic acts on them
// Notes:   all outputs are registered; reset outputs are active low
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer #(
    parameter logic [pss_pkg::CNT_W-1:0] QUAL_CYC = pss_pkg::CNT_W'(pss_pkg::QUAL_CYC_DEF)
) (
    input  wire logic                       clock,
    input  wire logic                       rstn,
    input  wire logic                       clk_en,
    input  wire logic                       bat_monitor_cmp,
    input  wire logic                       bat_startup_cmp,
    input  wire logic                       bat_shutdown_cmp,
    input  wire logic                       core_shutdown_cmp,
    input  wire logic                       bat_user_cmp,
    input  wire logic                       wafer_pkg,
    input  wire logic                       boot_done,
    input  wire logic                       mon_clear,
    output logic                            sys_rstn,
    output logic                            core_rstn,
    output logic                            units_en,
    output logic                            audio_en,
    output logic                            reg_en,
    output logic                            cp_en,
    output logic                            system_clock_net_connect,
    output logic                            ext_clk_sel,
    output logic                            boot_start,
    output logic [pss_pkg::VSET_W-1:0]      core_vset,
    output logic                            vset_we,
    output logic                            cp_refresh,
    output logic [pss_pkg::MON_W-1:0]       mon_count,
    output logic [3:0]                      seq_state
);
    // ****************************************
    // synchronisers
    // ****************************************
    pss_sync_if sif ();

    pss_sync u_sync (
        .clock (clock),
        .rstn  (rstn),
        .clk_en(clk_en),
        .raw   ({bat_user_cmp, core_shutdown_cmp, bat_shutdown_cmp,
                 bat_startup_cmp, bat_monitor_cmp}),
        .sync  (sif.src)
    );

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        pss_pkg::pss_state_e            st;
        logic [pss_pkg::CNT_W-1:0]      cnt;
        logic [11:0]                    cp_div;
        logic                           cp_pulse;
        logic                           user_prev;
        logic [pss_pkg::MON_W-1:0]      mon;
        logic [pss_pkg::VSET_W-1:0]     vset;
        logic                           vset_we;
        logic                           boot_start;
    } pss_seq_s;

    pss_seq_s s_r;
    pss_seq_s s_nxt;

    logic supply_ok;
    logic [pss_pkg::CNT_W-1:0] step_cyc;

    always_comb begin
        // falling under 0.80 V on either supply, or monitor not alive, forces shutdown
        supply_ok = sif.bat_monitor_ok && sif.bat_above_shutdown
                    && sif.core_above_shutdown;
        case (s_r.st)
            pss_pkg::ST_REG_ON:  step_cyc = pss_pkg::CNT_W'(pss_pkg::REG_SETTLE_CYC);
            pss_pkg::ST_CP_ON:   step_cyc = pss_pkg::CNT_W'(pss_pkg::CP_SETTLE_CYC);
            default:             step_cyc = pss_pkg::CNT_W'(pss_pkg::CLK_SETTLE_CYC);
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        if (clk_en) begin
            s_nxt.vset_we    = 1'b0;
            s_nxt.boot_start = 1'b0;
            // refresh tick from the free-running slow clock divider
            if (s_r.cp_div == 12'(pss_pkg::CP_REFRESH_DIV - 1)) begin
                s_nxt.cp_div   = 12'h000;
                s_nxt.cp_pulse = (s_r.st != pss_pkg::ST_OFF) &&
                                 (s_r.st != pss_pkg::ST_QUAL) &&
                                 (s_r.st != pss_pkg::ST_REG_ON);
            end else begin
                s_nxt.cp_div   = s_r.cp_div + 12'h001;
                s_nxt.cp_pulse = 1'b0;
            end
            // count falling edges of the user threshold; saturate, never wrap
            s_nxt.user_prev = sif.bat_above_user;
            if (mon_clear) begin
                s_nxt.mon = pss_pkg::MON_CNT_RST;
            end
            // a fall in the clear cycle still counts, even from saturation
            if (s_r.user_prev && !sif.bat_above_user && sif.bat_monitor_ok
                && (mon_clear || s_r.mon != pss_pkg::MON_CNT_MAX)) begin
                s_nxt.mon = (mon_clear ? pss_pkg::MON_CNT_RST : s_r.mon)
                            + 16'h0001;
            end
            case (s_r.st)
                pss_pkg::ST_OFF: begin
                    s_nxt.cnt = '0;
                    if (sif.bat_monitor_ok) begin
                        s_nxt.st = pss_pkg::ST_QUAL;
                    end
                end
                pss_pkg::ST_QUAL: begin
                    if (!sif.bat_monitor_ok) begin
                        s_nxt.st = pss_pkg::ST_OFF;
                    end else if (!sif.bat_startup_ok || !supply_ok) begin
                        s_nxt.cnt = '0;
                    end else if (s_r.cnt >= QUAL_CYC - 1'b1) begin
                        s_nxt.cnt = '0;
                        s_nxt.st  = pss_pkg::ST_REG_ON;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 1'b1;
                    end
                end
                pss_pkg::ST_REG_ON, pss_pkg::ST_CP_ON, pss_pkg::ST_CLK_ON,
                pss_pkg::ST_EXT_CLK: begin
                    if (s_r.cnt >= step_cyc - 1'b1) begin
                        s_nxt.cnt = '0;
                        case (s_r.st)
                            pss_pkg::ST_REG_ON: s_nxt.st = pss_pkg::ST_CP_ON;
                            pss_pkg::ST_CP_ON:  s_nxt.st = pss_pkg::ST_CLK_ON;
                            pss_pkg::ST_CLK_ON: s_nxt.st = wafer_pkg ? pss_pkg::ST_EXT_CLK
                                                                     : pss_pkg::ST_BOOT;
                            default:            s_nxt.st = pss_pkg::ST_BOOT;
                        endcase
                        if (s_nxt.st == pss_pkg::ST_BOOT) begin
                            s_nxt.boot_start = 1'b1;
                            s_nxt.vset       = wafer_pkg ? pss_pkg::VSET_MAX
                                                         : s_r.vset;
                            s_nxt.vset_we    = wafer_pkg;
                        end
                    end else begin
                        s_nxt.cnt = s_r.cnt + 1'b1;
                    end
                end
                pss_pkg::ST_BOOT: begin
                    if (boot_done) begin
                        s_nxt.st = pss_pkg::ST_RUN;
                    end
                end
                pss_pkg::ST_RUN: begin
                end
                default: begin
                    s_nxt.st = pss_pkg::ST_OFF;
                end
            endcase
            // any brown-out after qualification drops every output except mon_count back
            if (s_r.st != pss_pkg::ST_OFF && s_r.st != pss_pkg::ST_QUAL && !supply_ok) begin
                s_nxt.st         = pss_pkg::ST_OFF;
                s_nxt.cnt        = '0;
                s_nxt.boot_start = 1'b0;
                s_nxt.vset_we    = 1'b0;
                s_nxt.vset       = pss_pkg::VSET_RST;
                s_nxt.cp_pulse   = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_r      <= '0;
            s_r.st   <= pss_pkg::ST_OFF;
            s_r.mon  <= pss_pkg::MON_CNT_RST;
            s_r.vset <= pss_pkg::VSET_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sys_rstn       <= 1'b0;
            core_rstn      <= 1'b0;
            units_en       <= 1'b0;
            audio_en       <= 1'b0;
            reg_en         <= 1'b0;
            cp_en          <= 1'b0;
            system_clock_net_connect <= 1'b0;
            ext_clk_sel    <= 1'b0;
            boot_start     <= 1'b0;
            core_vset      <= pss_pkg::VSET_RST;
            vset_we        <= 1'b0;
            cp_refresh     <= 1'b0;
            mon_count      <= pss_pkg::MON_CNT_RST;
            seq_state      <= 4'h0;
        end else if (clk_en) begin
            // registers stay in reset until boot begins, audio until running
            sys_rstn       <= (s_nxt.st == pss_pkg::ST_BOOT) ||
                              (s_nxt.st == pss_pkg::ST_RUN);
            core_rstn      <= (s_nxt.st == pss_pkg::ST_BOOT) ||
                              (s_nxt.st == pss_pkg::ST_RUN);
            units_en       <= (s_nxt.st == pss_pkg::ST_RUN);
            audio_en       <= (s_nxt.st == pss_pkg::ST_RUN);
            reg_en         <= (s_nxt.st >= pss_pkg::ST_REG_ON);
            cp_en          <= (s_nxt.st >= pss_pkg::ST_CP_ON);
            system_clock_net_connect <= (s_nxt.st >= pss_pkg::ST_CLK_ON);
            ext_clk_sel    <= wafer_pkg && (s_nxt.st >= pss_pkg::ST_EXT_CLK);
            boot_start     <= s_nxt.boot_start;
            core_vset      <= s_nxt.vset;
            vset_we        <= s_nxt.vset_we;
            cp_refresh     <= s_nxt.cp_pulse;
            mon_count      <= s_nxt.mon;
            seq_state      <= 4'(s_nxt.st);
        end
    end
endmodule : pss_sequencer
`default_nettype wire

/* File: pss_sequencer_test.sv */
// Purpose: self-checking bench for the power sequencer
// Assumes: small qualify count keeps the run short
// Notes:   partner model turns millivolts into comparator levels
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_test;
    localparam logic [23:0] QUAL = 24'h000014;
    logic        clock = 1'b0, rstn = 1'b0, clk_en = 1'b1, wafer_pkg = 1'b1;
    logic        boot_done = 1'b0, mon_clear = 1'b0;
    logic [11:0] bat_mv = 12'h000, core_mv = 12'h000, user_mv = 12'h5dc;
    logic        bat_monitor_cmp, bat_startup_cmp, bat_shutdown_cmp, core_shutdown_cmp;
    logic        bat_user_cmp, sys_rstn, core_rstn, units_en, audio_en, reg_en, cp_en;
    logic        system_clock_net_connect, ext_clk_sel, boot_start, vset_we, cp_refresh;
    logic [3:0]  core_vset, seq_state;
    logic [15:0] mon_count;
    int          num_errors = 0, n_compared = 0, cyc = 0;
    always #5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    pss_supply_model sup (.bat_mv, .core_mv, .user_mv, .bat_monitor_cmp, .bat_startup_cmp,
        .bat_shutdown_cmp, .core_shutdown_cmp, .bat_user_cmp);
    pss_sequencer #(.QUAL_CYC(QUAL)) uut (.clock, .rstn, .clk_en, .bat_monitor_cmp,
        .bat_startup_cmp, .bat_shutdown_cmp, .core_shutdown_cmp, .bat_user_cmp, .wafer_pkg,
        .boot_done, .mon_clear, .sys_rstn, .core_rstn, .units_en, .audio_en, .reg_en, .cp_en,
        .system_clock_net_connect, .ext_clk_sel, .boot_start, .core_vset, .vset_we, .cp_refresh,
        .mon_count, .seq_state);
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s seen %0h want %0h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    function automatic logic pick(input int s);
        case (s)
            0: return reg_en;
            1: return cp_en;
            2: return system_clock_net_connect;
            3: return ext_clk_sel;
            4: return sys_rstn;
            5: return audio_en;
            default: return cp_refresh;
        endcase
    endfunction : pick
    // bounded wait; a miss returns a time far off so the gap check fails
    task automatic wait_hi(input int s, input int lim, output int at);
        int n;
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
        at = (n < lim) ? cyc : -100000;
    endtask : wait_hi
    task automatic power_up(input logic wlp, output int t0);
        int t1, t2, t3, t4;
        @(posedge clock) begin
            wafer_pkg <= wlp;
            bat_mv    <= 12'h708;
            core_mv   <= 12'h4b0;
        end
        wait_hi(0, 100, t0);
        wait_hi(1, 2100, t1);
        chk(t1 - t0, pss_pkg::REG_SETTLE_CYC, "charge pump delay");
        wait_hi(2, 2100, t2);
        chk(t2 - t1, pss_pkg::CP_SETTLE_CYC, "clock connect delay");
        t3 = t2;
        if (wlp) wait_hi(3, 300, t3);
        chk(t3 - t2, wlp ? pss_pkg::CLK_SETTLE_CYC : 0, "external clock delay");
        wait_hi(4, 300, t4);
        chk(t4 - t3, pss_pkg::CLK_SETTLE_CYC, "boot delay");
        chk({boot_start, ext_clk_sel, vset_we, audio_en}, {1'b1, wlp, wlp, 1'b0}, "boot");
        chk(core_vset, wlp ? pss_pkg::VSET_MAX : pss_pkg::VSET_RST, "vset");
        @(posedge clock) boot_done <= 1'b1;
        @(posedge clock) boot_done <= 1'b0;
        wait_hi(5, 4, t1);
        chk({units_en, audio_en, seq_state}, {2'b11, 4'h7}, "run");
    endtask : power_up
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_floor;
        chk({sys_rstn, audio_en, reg_en, core_vset, seq_state}, 0, "reset");
        // frozen by the clock enable, the sequencer must not leave off
        @(posedge clock) begin
            clk_en <= 1'b0;
            bat_mv <= 12'h32a;
        end
        tick(10);
        chk(seq_state, 4'h0, "frozen");
        @(posedge clock) clk_en <= 1'b1;
        tick(200);
        chk({seq_state, reg_en, sys_rstn}, {4'h1, 2'b00}, "below startup");
        $display("floor test done");
    endtask : t_floor
    task automatic t_dip_boot;
        int td, t0;
        // both supplies good so qualification really runs before the dip
        @(posedge clock) begin
            bat_mv  <= 12'h708;
            core_mv <= 12'h4b0;
        end
        tick(15);
        @(posedge clock) bat_mv <= 12'h32a;
        tick(2);
        td = cyc;
        power_up(1'b1, t0);
        chk(t0 - td >= 20, 1, "qualify restart");
        wait_hi(6, 3300, td);
        tick(1);
        wait_hi(6, 3300, t0);
        chk(t0 - td, pss_pkg::CP_REFRESH_DIV, "refresh spacing");
        $display("dip and boot test done");
    endtask : t_dip_boot
    task automatic t_monitor;
        @(posedge clock) mon_clear <= 1'b1;
        @(posedge clock) mon_clear <= 1'b0;
        tick(3);
        chk(mon_count, 16'h0000, "clear");
        repeat (3) begin
            @(posedge clock) bat_mv <= 12'h578;
            tick(8);
            @(posedge clock) bat_mv <= 12'h708;
            tick(8);
        end
        chk(mon_count, 16'h0003, "fall count");
        $display("monitor test done");
    endtask : t_monitor
    task automatic t_brownout;
        int t0;
        @(posedge clock) core_mv <= 12'h2bc;
        tick(6);
        chk({sys_rstn, units_en, audio_en, core_vset}, 0, "core drop");
        power_up(1'b0, t0);
        @(posedge clock) bat_mv <= 12'h30c;
        tick(6);
        chk({sys_rstn, core_rstn, units_en, audio_en, cp_en}, 0, "battery drop");
        $display("brownout test done");
    endtask : t_brownout
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        tick(10);
        t_floor();
        t_dip_boot();
        t_monitor();
        t_brownout();
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge clock);
        num_errors++;
        $display("BAD %0t run did not finish", $time);
        wrap_up();
    end
endmodule : pss_sequencer_test
bind pss_sequencer pss_sva #(.QUAL_CYC(QUAL_CYC)) sva_i (.clock, .rstn, .bat_startup_cmp,
    .bat_shutdown_cmp, .core_shutdown_cmp, .wafer_pkg, .mon_clear, .sys_rstn, .core_rstn,
    .units_en, .audio_en, .reg_en, .cp_en, .system_clock_net_connect, .ext_clk_sel, .boot_start,
    .core_vset, .vset_we, .cp_refresh, .mon_count);
`default_nettype wire

/* File: pss_supply_model.sv */
// Purpose: behavioural supply comparators facing the sequencer
// Assumes: bench gives voltages in millivolts
// Notes:   ideal comparators, no hysteresis or noise
`timescale 1ns/1ps
`default_nettype none
module pss_supply_model #(
    parameter int MON_MV  = 700,
    parameter int UP_MV   = 820,
    parameter int DOWN_MV = 800
) (
    input  wire logic [11:0] bat_mv,
    input  wire logic [11:0] core_mv,
    input  wire logic [11:0] user_mv,
    output logic             bat_monitor_cmp,
    output logic             bat_startup_cmp,
    output logic             bat_shutdown_cmp,
    output logic             core_shutdown_cmp,
    output logic             bat_user_cmp
);
    assign bat_monitor_cmp   = bat_mv >= 12'(MON_MV);
    assign bat_startup_cmp   = bat_mv >= 12'(UP_MV);
    assign bat_shutdown_cmp  = bat_mv >= 12'(DOWN_MV);
    assign core_shutdown_cmp = core_mv >= 12'(DOWN_MV);
    assign bat_user_cmp      = bat_mv > user_mv;
endmodule : pss_supply_model
`default_nettype wire

/* File: pss_sva.sv */
// Purpose: port assertions for the power sequencer
// Assumes: clk_en only dropped by the bench before the charge pump starts
// Notes:   windows allow two sync flops and one state step
`timescale 1ns/1ps
`default_nettype none
module pss_sva #(
    parameter logic [pss_pkg::CNT_W-1:0] QUAL_CYC = 20
) (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        bat_startup_cmp,
    input wire logic        bat_shutdown_cmp,
    input wire logic        core_shutdown_cmp,
    input wire logic        wafer_pkg,
    input wire logic        mon_clear,
    input wire logic        sys_rstn,
    input wire logic        core_rstn,
    input wire logic        units_en,
    input wire logic        audio_en,
    input wire logic        reg_en,
    input wire logic        cp_en,
    input wire logic        system_clock_net_connect,
    input wire logic        ext_clk_sel,
    input wire logic        boot_start,
    input wire logic [3:0]  core_vset,
    input wire logic        vset_we,
    input wire logic        cp_refresh,
    input wire logic [15:0] mon_count
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    int unsigned up_run_r;
    int unsigned cp_gap_r;
    logic        cp_seen_r;
    // gap only judged after a first pulse, the divider phase is free at start
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            up_run_r  <= 0;
            cp_gap_r  <= 0;
            cp_seen_r <= 1'b0;
        end else begin
            up_run_r  <= bat_startup_cmp ? up_run_r + 1 : 0;
            cp_gap_r  <= (cp_refresh || !cp_en) ? 0 : cp_gap_r + 1;
            cp_seen_r <= cp_en && (cp_seen_r || cp_refresh);
        end
    end
    bat_drop_a: assert property (!bat_shutdown_cmp [*5] |-> !sys_rstn && !units_en)
        else $error("no reset after battery drop");
    core_drop_a: assert property (!core_shutdown_cmp [*5] |-> !core_rstn && !audio_en)
        else $error("no reset after core supply drop");
    rst_pair_a: assert property (sys_rstn == core_rstn)
        else $error("system and core resets differ");
    audio_gate_a: assert property (audio_en |-> units_en && sys_rstn && system_clock_net_connect)
        else $error("audio enabled outside run");
    step_order_a: assert property ((!cp_en || reg_en) && (!system_clock_net_connect || cp_en))
        else $error("stabilization steps out of order");
    ext_clk_a: assert property (ext_clk_sel |-> system_clock_net_connect && wafer_pkg)
        else $error("external clock without wafer option");
    boot_after_a: assert property ($rose(sys_rstn) |-> boot_start && ext_clk_sel == wafer_pkg)
        else $error("boot began before stabilization done");
    vset_max_a: assert property (boot_start |-> vset_we == wafer_pkg
        && core_vset == (wafer_pkg ? pss_pkg::VSET_MAX : pss_pkg::VSET_RST))
        else $error("regulator setting wrong at boot");
    qual_time_a: assert property ($rose(reg_en) |-> up_run_r >= QUAL_CYC)
        else $error("startup before qualify time");
    cp_gap_a: assert property (cp_seen_r && cp_en
        |-> cp_refresh == (cp_gap_r == pss_pkg::CP_REFRESH_DIV - 1))
        else $error("charge pump refresh spacing wrong");
    mon_step_a: assert property (mon_count != $past(mon_count) && !$past(mon_clear)
        |-> mon_count == $past(mon_count) + 16'h0001)
        else $error("monitor count jumped");
    run_c: cover property ($rose(audio_en));
    refresh_c: cover property (cp_refresh && cp_seen_r);
    mon_c: cover property (mon_count == 16'h0003);
endmodule : pss_sva
`default_nettype wire

/* File: pss_sync.sv */
// Purpose: two-stage synchronisers for the five comparator levels
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module pss_sync (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    input  wire logic [4:0] raw,
    pss_sync_if.src         sync
);
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
    } pss_sync_s;

    pss_sync_s st_r;
    pss_sync_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (clk_en) begin
            st_nxt.s1 = raw;
            st_nxt.s2 = st_r.s1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync.bat_monitor_ok      = st_r.s2[0];
    assign sync.bat_startup_ok      = st_r.s2[1];
    assign sync.bat_above_shutdown  = st_r.s2[2];
    assign sync.core_above_shutdown = st_r.s2[3];
    assign sync.bat_above_user      = st_r.s2[4];
endmodule : pss_sync
`default_nettype wire

/* File: pss_sync_if.sv */
// Purpose: carries synchronised comparator levels between the modules
// Assumes: all signals on the one system clock
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface pss_sync_if;
    logic bat_monitor_ok;
    logic bat_startup_ok;
    logic bat_above_shutdown;
    logic core_above_shutdown;
    logic bat_above_user;
    modport src (output bat_monitor_ok, bat_startup_ok, bat_above_shutdown,
                 core_above_shutdown, bat_above_user);
    modport dst (input bat_monitor_ok, bat_startup_ok, bat_above_shutdown,
                 core_above_shutdown, bat_above_user);
endinterface : pss_sync_if
`default_nettype wire
